// >>> hw/sca_top.v
// Stream channel adapter with an APB status and control slave
//
// What this block does
// (R1) Flag nonzero channel when sink lacks channels
// (R2) Tie sink channel to zero without source channel
// (R3) Forward channel, zero-fill extra sink bits
// (R4) Forward low channel bits, drop surplus bits
// (R5) Flag beats above sink maximum channel
// (R6) Hold sink valid low for such beats
// (R7) Channel widths zero to eight bits
// (R8) Maximum channel parameter zero to 255
// (R9) Error width zero to 31, passed through
// (R10) Ready passes through, latency unchanged
// (R11) Packet delimiters and empty pass unchanged
// (R12) Symbol size identical on both sides
// (R13) Everything else passes through unmodified
// (R14) Combinational path, error in same cycle
`timescale 1ns/1ps
`include "sca_map.vh"
module sca_top #(
    parameter SYM_BITS      = 8,
    parameter SYMS_PER_BEAT = 4,
    parameter EMPTY_W       = 2,
    parameter IN_CHAN_W     = 4,
    parameter IN_MAX_CHAN   = 15,
    parameter OUT_CHAN_W    = 4,
    parameter OUT_MAX_CHAN  = 15,
    parameter ERR_W         = 1,
    parameter ADDR_W        = 8
) (
    input  wire                       pclk,
    input  wire                       presetn,
    // APB slave
    input  wire [ADDR_W-1:0]          paddr,
    input  wire                       psel,
    input  wire                       penable,
    input  wire                       pwrite,
    input  wire [31:0]                pwdata,
    output reg                        pready,
    output reg  [31:0]                prdata,
    output reg                        pslverr,
    // Source side
    input  wire                       src_valid,
    output wire                       src_ready,
    input  wire [SYM_BITS*SYMS_PER_BEAT-1:0] src_data,
    input  wire [((IN_CHAN_W == 0) ? 1 : IN_CHAN_W)-1:0] src_chan,
    input  wire                       src_sop,
    input  wire                       src_eop,
    input  wire [EMPTY_W-1:0]         src_empty,
    input  wire [((ERR_W == 0) ? 1 : ERR_W)-1:0] src_error,
    // Sink side
    output wire                       snk_valid,
    input  wire                       snk_ready,
    output wire [SYM_BITS*SYMS_PER_BEAT-1:0] snk_data,
    output wire [((OUT_CHAN_W == 0) ? 1 : OUT_CHAN_W)-1:0] snk_chan,
    output wire                       snk_sop,
    output wire                       snk_eop,
    output wire [EMPTY_W-1:0]         snk_empty,
    output wire [((ERR_W == 0) ? 1 : ERR_W)-1:0] snk_error,
    output wire                       chan_error
);
    // Zero-width fields keep a one-bit port that is ignored or driven zero
    localparam CIW = (IN_CHAN_W  == 0) ? 1 : IN_CHAN_W;                  // (R7)
    localparam COW = (OUT_CHAN_W == 0) ? 1 : OUT_CHAN_W;                 // (R7)
    localparam EW  = (ERR_W == 0) ? 1 : ERR_W;                          // (R9)

    // Configuration figures as seen by software
    localparam [3:0] CFG_IN_W    = IN_CHAN_W[3:0];
    localparam [3:0] CFG_OUT_W   = OUT_CHAN_W[3:0];
    localparam [7:0] CFG_OUT_MAX = OUT_MAX_CHAN[7:0];
    localparam [7:0] CFG_IN_MAX  = IN_MAX_CHAN[7:0];
    localparam [4:0] CFG_ERR_W   = ERR_W[4:0];
    // Reset value of the control word; only the enable bit is stored
    localparam [31:0] CTRL_RST_WORD = `SCA_CTRL_RST;
    // Parameters inside their legal ranges; reported to software, not enforced
    localparam PARAM_OK = (IN_CHAN_W <= `SCA_CHAN_W_MAX) && (OUT_CHAN_W <= `SCA_CHAN_W_MAX) &&
                          (IN_MAX_CHAN <= `SCA_CHAN_MAX_LIMIT) && (OUT_MAX_CHAN <= `SCA_CHAN_MAX_LIMIT) &&
                          (ERR_W <= `SCA_ERR_W_MAX);                                    // (R7) (R8) (R9)
    localparam [31:0] LEGAL_WORD = PARAM_OK ? (32'h0000_0001 << `SCA_CFG_LEGAL_BIT) : 32'h0000_0000;

    localparam [31:0] CONFIG_WORD =
        ({28'h0000000, CFG_IN_W}    << `SCA_CFG_IN_W_LSB)   |
        ({28'h0000000, CFG_OUT_W}   << `SCA_CFG_OUT_W_LSB)  |
        ({24'h000000,  CFG_OUT_MAX} << `SCA_CFG_OUT_MAX_LSB) |
        ({24'h000000,  CFG_IN_MAX}  << `SCA_CFG_IN_MAX_LSB)  |
        ({27'h0000000, CFG_ERR_W}   << `SCA_CFG_ERR_W_LSB)   |
        LEGAL_WORD;

    // Address match against a register offset, used by every decode
    function reg_hit;
        input [ADDR_W-1:0] addr;
        input [7:0]        ofs;
        reg   [ADDR_W+7:0] addr_ext;
        begin
            // Widened compare works for any ADDR_W; upper address bits must be zero
            addr_ext = {8'h00, addr};
            reg_hit  = (addr_ext == {{ADDR_W{1'b0}}, ofs});
        end
    endfunction

    // Saturating increment shared by both beat counters
    function [15:0] sat_inc;
        input [15:0] value;
        begin
            if (value == 16'hFFFF) begin
                sat_inc = value;
            end else begin
                sat_inc = value + 16'h0001;
            end
        end
    endfunction

    wire [7:0] chan_value;
    wire       out_of_range;

    // Channel mapping and range check live in the leaf
    sca_chan_map #(
        .IN_CHAN_W    (IN_CHAN_W),
        .OUT_CHAN_W   (OUT_CHAN_W),
        .OUT_MAX_CHAN (OUT_MAX_CHAN)
    ) u_map (
        .src_chan     (src_chan),
        .snk_chan     (snk_chan),
        .chan_value   (chan_value),
        .out_of_range (out_of_range)
    );

    // Stream path has no flip-flop: adding one would shift ready_to_data_cycles
    assign chan_error = src_valid & out_of_range;                        // (R5) (R14)
    assign snk_valid  = src_valid & ~out_of_range;                       // (R6) (R14)
    assign src_ready  = snk_ready;                                       // (R10)
    assign snk_data   = src_data;                                        // (R12) (R13)
    assign snk_sop    = src_sop;                                         // (R11)
    assign snk_eop    = src_eop;                                         // (R11)
    assign snk_empty  = src_empty;                                       // (R11)
    assign snk_error  = (ERR_W == 0) ? {EW{1'b0}} : src_error;           // (R9)

    // APB answer sequencer states
    localparam [0:0] APB_IDLE   = 1'b0;
    localparam [0:0] APB_ANSWER = 1'b1;   // pready stands in this state

    reg        apb_state;
    reg        next_apb_state;

    // Next values of the flags and counters
    reg        next_range_err;
    reg        next_seen_beat;
    reg [15:0] next_err_count;
    reg [15:0] next_pass_count;

    // Software-visible state
    reg [15:0] pass_count;
    reg        cnt_en;
    reg        range_err;
    reg        seen_beat;
    reg [15:0] err_count;
    reg [7:0]  last_bad_chan;

    wire apb_access = psel & penable & (apb_state == APB_IDLE);
    wire apb_write  = psel & penable & pwrite & (apb_state == APB_ANSWER);
    wire hit_ctrl   = reg_hit(paddr, `SCA_CTRL_OFS);
    wire hit_status = reg_hit(paddr, `SCA_STATUS_OFS);
    wire hit_errcnt = reg_hit(paddr, `SCA_ERRCNT_OFS);
    wire hit_lastch = reg_hit(paddr, `SCA_LASTCH_OFS);
    wire hit_config = reg_hit(paddr, `SCA_CONFIG_OFS);
    wire hit_passcnt = reg_hit(paddr, `SCA_PASSCNT_OFS);
    wire hit_any    = hit_ctrl | hit_status | hit_errcnt | hit_lastch | hit_config | hit_passcnt;
    wire good_beat  = src_valid & ~out_of_range;                         // (R6) (R13)
    wire bad_beat   = src_valid & out_of_range;                          // (R5)
    wire clr_req    = apb_write & hit_ctrl & pwdata[`SCA_CTRL_CNT_CLR];
    wire w1c_err    = apb_write & hit_status & pwdata[`SCA_STAT_RANGE_ERR];
    wire w1c_seen   = apb_write & hit_status & pwdata[`SCA_STAT_SEEN_BEAT];

    reg [31:0] next_rdata;

    // Read mux; unmapped addresses read zero and flag an error
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_rdata[`SCA_CTRL_CNT_EN] = cnt_en;
        end else if (hit_status) begin
            next_rdata[`SCA_STAT_RANGE_ERR] = range_err;
            next_rdata[`SCA_STAT_SEEN_BEAT] = seen_beat;
        end else if (hit_errcnt) begin
            next_rdata[15:0] = err_count;
        end else if (hit_lastch) begin
            next_rdata[7:0] = last_bad_chan;
        end else if (hit_config) begin
            next_rdata = CONFIG_WORD;
        end else if (hit_passcnt) begin
            next_rdata[15:0] = pass_count;
        end
    end

    // One wait state: the answer follows the first access cycle
    always @* begin
        next_apb_state = APB_IDLE;
        case (apb_state)
            APB_IDLE: begin
                if (psel && penable) begin
                    next_apb_state = APB_ANSWER;
                end
            end
            APB_ANSWER: begin
                next_apb_state = APB_IDLE;
            end
            default: begin
                next_apb_state = APB_IDLE;
            end
        endcase
    end

    // Answer registers: pready, read data and error stand for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= APB_IDLE;
            pready    <= 1'b0;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else begin
            apb_state <= next_apb_state;
            pready    <= (next_apb_state == APB_ANSWER);
            pslverr   <= apb_access & ~hit_any;
            if (apb_access && !pwrite) begin
                prdata <= next_rdata;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Control: the counter enable steers whether good and bad beats are counted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_en <= CTRL_RST_WORD[`SCA_CTRL_CNT_EN];
        end else if (apb_write && hit_ctrl) begin
            cnt_en <= pwdata[`SCA_CTRL_CNT_EN];
        end
    end

    // Sticky flags: a new event in the clearing cycle wins over the clear
    always @* begin
        next_range_err = range_err;
        next_seen_beat = seen_beat;
        if (w1c_err) begin
            next_range_err = 1'b0;
        end
        if (bad_beat) begin
            next_range_err = 1'b1;                                       // (R5)
        end
        if (w1c_seen) begin
            next_seen_beat = 1'b0;
        end
        if (src_valid) begin
            next_seen_beat = 1'b1;
        end
    end

    // Counters saturate; a clear racing a counted beat leaves a count of one
    always @* begin
        next_err_count  = err_count;
        next_pass_count = pass_count;
        if (clr_req) begin
            next_err_count  = 16'h0000;
            next_pass_count = 16'h0000;
        end
        if (bad_beat && cnt_en) begin
            next_err_count = sat_inc(clr_req ? 16'h0000 : err_count);
        end
        if (good_beat && cnt_en) begin
            next_pass_count = sat_inc(clr_req ? 16'h0000 : pass_count);
        end
    end

    // Flags and counters
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_err  <= 1'b0;
            seen_beat  <= 1'b0;
            err_count  <= 16'h0000;
            pass_count <= 16'h0000;
        end else begin
            range_err  <= next_range_err;
            seen_beat  <= next_seen_beat;
            err_count  <= next_err_count;
            pass_count <= next_pass_count;
        end
    end

    // Last channel that was refused, kept for diagnosis
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_bad_chan <= 8'h00;
        end else if (bad_beat) begin
            last_bad_chan <= chan_value;
        end
    end
endmodule // sca_top

// >>> hw/sca_map.vh
// Register offsets, field positions and reset values of the stream channel adapter
`ifndef SCA_MAP_VH
`define SCA_MAP_VH

// Register byte offsets on the APB side
`define SCA_CTRL_OFS        8'h00
`define SCA_STATUS_OFS      8'h04
`define SCA_ERRCNT_OFS      8'h08
`define SCA_LASTCH_OFS      8'h0C
`define SCA_CONFIG_OFS      8'h10
`define SCA_PASSCNT_OFS     8'h14

// Control register fields
`define SCA_CTRL_CNT_EN     0
`define SCA_CTRL_CNT_CLR    1
`define SCA_CTRL_RST        32'h0000_0001

// Status register fields
`define SCA_STAT_RANGE_ERR  0
`define SCA_STAT_SEEN_BEAT  1

// Config register field positions
`define SCA_CFG_IN_W_LSB    0
`define SCA_CFG_OUT_W_LSB   4
`define SCA_CFG_OUT_MAX_LSB 8
`define SCA_CFG_IN_MAX_LSB  16
`define SCA_CFG_ERR_W_LSB   24
`define SCA_CFG_LEGAL_BIT   31

// Channel field and error width limits
`define SCA_CHAN_W_MAX      8
`define SCA_CHAN_MAX_LIMIT  255
`define SCA_ERR_W_MAX       31

`endif

// >>> hw/sca_chan_map.v
// Channel field mapping and range check between source and sink
`timescale 1ns/1ps
module sca_chan_map #(
    parameter IN_CHAN_W    = 4,
    parameter OUT_CHAN_W   = 4,
    parameter OUT_MAX_CHAN = 15
) (
    input  wire [((IN_CHAN_W  == 0) ? 1 : IN_CHAN_W)-1:0]  src_chan,
    output wire [((OUT_CHAN_W == 0) ? 1 : OUT_CHAN_W)-1:0] snk_chan,
    output wire [7:0]                                      chan_value,
    output wire                                            out_of_range
);
    localparam IW = (IN_CHAN_W  == 0) ? 1 : IN_CHAN_W;
    localparam OW = (OUT_CHAN_W == 0) ? 1 : OUT_CHAN_W;
    // A sink without channels accepts only channel zero
    localparam [7:0] MAX_EFF = (OUT_CHAN_W == 0) ? 8'h00 : OUT_MAX_CHAN[7:0];

    wire [7+IW:0] widened;
    wire [7:0]    src_ext;
    wire [7+OW:0] out_pad;

    // Zero-extend the source channel to the full eight-bit range
    assign widened  = {8'h00, src_chan};
    assign src_ext  = (IN_CHAN_W == 0) ? 8'h00 : widened[7:0];
    assign out_pad  = {{OW{1'b0}}, src_ext};
    // Low bits pass unchanged, upper sink bits are zero, extra source bits dropped
    assign snk_chan = (OUT_CHAN_W == 0) ? {OW{1'b0}} : out_pad[OW-1:0];   // (R2) (R3) (R4)
    assign chan_value   = src_ext;
    assign out_of_range = (src_ext > MAX_EFF);                           // (R1) (R5) (R8)
endmodule // sca_chan_map

// >>> testbench/sca_top_sva.sv
// Port assertions for the stream channel adapter
`timescale 1ns/1ps
module sca_top_sva #(
    parameter IN_CHAN_W    = 4,
    parameter OUT_CHAN_W   = 4,
    parameter OUT_MAX_CHAN = 15,
    parameter EMPTY_W      = 2,
    parameter ERR_W        = 1
) (
    input wire                  pclk,
    input wire                  presetn,
    input wire                  psel,
    input wire                  penable,
    input wire                  pready,
    input wire                  src_valid,
    input wire                  src_ready,
    input wire [((IN_CHAN_W == 0) ? 1 : IN_CHAN_W)-1:0] src_chan,
    input wire                  src_sop,
    input wire                  src_eop,
    input wire [EMPTY_W-1:0]    src_empty,
    input wire [((ERR_W == 0) ? 1 : ERR_W)-1:0] src_error,
    input wire                  snk_valid,
    input wire                  snk_ready,
    input wire [((OUT_CHAN_W == 0) ? 1 : OUT_CHAN_W)-1:0] snk_chan,
    input wire                  snk_sop,
    input wire                  snk_eop,
    input wire [EMPTY_W-1:0]    snk_empty,
    input wire [((ERR_W == 0) ? 1 : ERR_W)-1:0] snk_error,
    input wire                  chan_error
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Full source value is compared, so dropped upper bits still count
    wire range_bad = src_valid && (src_chan > OUT_MAX_CHAN);
    // Setup cycle followed by the first access cycle
    sequence apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    range_flag_a: assert property (range_bad |-> chan_error)
        else $error("range beat not flagged");
    valid_block_a: assert property (chan_error |-> !snk_valid && range_bad)
        else $error("refused beat reached sink");
    valid_pass_a: assert property (src_valid && !range_bad |-> snk_valid && !chan_error)
        else $error("good beat dropped");
    chan_low_a: assert property (snk_chan == src_chan[OUT_CHAN_W-1:0])
        else $error("channel low bits altered");
    ready_pass_a: assert property (src_ready == snk_ready)
        else $error("ready altered");
    pkt_pass_a: assert property (snk_sop == src_sop && snk_eop == src_eop)
        else $error("packet marks altered");
    side_pass_a: assert property (snk_empty == src_empty && (ERR_W == 0 || snk_error == src_error))
        else $error("empty or error bits altered");
    bad_hold_a: assert property (range_bad [*2] |-> chan_error && !snk_valid)
        else $error("flag lags offending beat");
    apb_answer_a: assert property (apb_access |=> pready ##1 !pready)
        else $error("apb answer late");
endmodule // sca_top_sva

bind sca_top sca_top_sva #(
    .IN_CHAN_W(IN_CHAN_W), .OUT_CHAN_W(OUT_CHAN_W), .OUT_MAX_CHAN(OUT_MAX_CHAN), .EMPTY_W(EMPTY_W), .ERR_W(ERR_W)
) u_sva (
    .pclk, .presetn, .psel, .penable, .pready, .src_valid, .src_ready, .src_chan, .src_sop, .src_eop, .src_empty,
    .src_error, .snk_valid, .snk_ready, .snk_chan, .snk_sop, .snk_eop, .snk_empty, .snk_error, .chan_error);

// >>> testbench/sca_sink_model.sv
// Streaming sink model with zero ready_to_data_cycles
`timescale 1ns/1ps
module sca_sink_model (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       stall,
    input  wire       snk_valid,
    output reg        snk_ready,
    output reg  [7:0] beats
);
    // A beat counts only where ready was already high, so latency stays zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snk_ready <= 1'b0;
            beats     <= 8'h00;
        end else begin
            snk_ready <= !stall;
            if (snk_valid && snk_ready) beats <= beats + 8'h01;
        end
    end
endmodule // sca_sink_model

// >>> testbench/sca_top_test.sv
// Self-checking bench for the stream channel adapter
`timescale 1ns/1ps
`include "sca_map.vh"
module sca_top_test;
    reg         pclk, presetn, psel, penable, pwrite, src_valid, src_sop, src_eop, src_error, stall, err;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, src_data, rd;
    reg  [4:0]  src_chan;
    reg  [1:0]  src_empty;
    wire        pready, pslverr, src_ready, snk_valid, snk_ready, snk_sop, snk_eop, chan_error, snk_error;
    wire [31:0] prdata, snk_data;
    wire [3:0]  snk_chan;
    wire [1:0]  snk_empty;
    wire [7:0]  beats;
    integer     bad_count, checks, i;
    // Boundary channels: 0, sink max 9, just above, dropped upper bit, source max
    localparam [24:0] CH = {5'd31, 5'd20, 5'd10, 5'd9, 5'd0};

    sca_top #(.IN_CHAN_W(5), .IN_MAX_CHAN(31), .OUT_CHAN_W(4), .OUT_MAX_CHAN(9)) u_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .src_valid, .src_ready, .src_data, .src_chan, .src_sop, .src_eop, .src_empty, .src_error,
        .snk_valid, .snk_ready, .snk_data, .snk_chan, .snk_sop, .snk_eop, .snk_empty, .snk_error, .chan_error);
    sca_sink_model u_sink (.pclk, .presetn, .stall, .snk_valid, .snk_ready, .beats);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Wait state count is not assumed; only the watchdog ends a hang
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd  = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // One beat per call; calls in a row give back to back beats
    task beat(input [4:0] c, input [31:0] d);
        begin
            @(posedge pclk);
            src_valid <= 1'b1;
            src_chan  <= c;
            src_data  <= d;
            {src_error, src_empty, src_eop, src_sop} <= d[4:0];
            #1;
            chk(chan_error, c > 9);
            chk(snk_valid, c <= 9);
            chk(snk_chan, c[3:0]);
            chk(snk_data, d);
            chk({snk_error, snk_empty, snk_eop, snk_sop}, d[4:0]);
            chk(src_ready, snk_ready);
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, src_valid, src_sop, src_eop, src_error, stall} = 9'h000;
        {paddr, pwdata, src_data, src_chan, src_empty} = 79'h0;
        bad_count = 0;
        checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SCA_CTRL_OFS, 32'h0);
        chk({err, rd[30:0]}, `SCA_CTRL_RST);
        apb(1'b0, `SCA_CONFIG_OFS, 32'h0);
        chk(rd, 32'h811F_0945);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk({err, rd[30:0]}, 32'h8000_0000);
        $display("test regs done");
        for (i = 0; i < 5; i = i + 1)
            beat(CH[i*5 +: 5], 32'hA5C3_0000 + i * 7);
        // Drop valid at once so each refused beat stands for one cycle only
        @(posedge pclk);
        src_valid <= 1'b0;
        stall     <= 1'b1;
        repeat (2) @(posedge pclk);
        beat(5'd5, 32'h0000_001F);
        @(posedge pclk);
        src_valid <= 1'b0;
        #1;
        chk({chan_error, snk_valid}, 32'h0);
        chk(beats, 32'h2);
        apb(1'b0, `SCA_ERRCNT_OFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, `SCA_LASTCH_OFS, 32'h0);
        chk(rd, 32'h1F);
        apb(1'b0, `SCA_PASSCNT_OFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, `SCA_STATUS_OFS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, `SCA_STATUS_OFS, 32'h3);
        apb(1'b0, `SCA_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("test stream done");
        // Clear and disable the counters, then refuse one more beat
        apb(1'b1, `SCA_CTRL_OFS, 32'h2);
        apb(1'b0, `SCA_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        beat(5'd12, 32'h0000_0003);
        @(posedge pclk);
        src_valid <= 1'b0;
        apb(1'b0, `SCA_ERRCNT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `SCA_LASTCH_OFS, 32'h0);
        chk(rd, 32'h0C);
        apb(1'b0, `SCA_STATUS_OFS, 32'h0);
        chk(rd, 32'h3);
        $display("test counter control done");
        complete_run;
    end

    // Whole run is under a hundred cycles
    initial begin
        #500000;
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule // sca_top_test
